// file: verilog/rsdte_port.sv
// top: terminal-side serial port with baud divider, transmitter and hold-off
`timescale 1ns/1ps
// How it works
// - six baud settings 300 to 9600, both ends must match
// - after reset: 9600 baud, even parity, seven data bits
// - with parity: start, seven data, parity bit, two stops
// - no parity: start, eight data, two stops; only with eight bits
// - exactly one start bit per frame, fixed
// - exactly two stop bits per frame, fixed
// - frame spans start through last stop; only baud and parity selectable, width follows parity
// - acts as terminal: drives hold-off out, watches partner ready in
// - hold-off raised when receive buffer holds about 100 characters
// - hold-off raised after query and newline until response fully sent
// - partner ready sampled before each character; sending waits while low
module rsdte_port #(
    parameter int unsigned CLK_HZ = rsdte_pkg::CLK_HZ // core clock rate, sets every divider
) (
    input wire logic clk,
    input wire logic reset,
    input wire rsdte_pkg::rsdte_cfg_t cfg_in,
    input wire logic cfg_load,
    input wire rsdte_pkg::rsdte_char_t tx_in,
    output logic tx_ready,
    output logic txd,
    input wire logic rxd,
    output rsdte_pkg::rsdte_rx_t rx_out,
    input wire logic [7:0] rx_level,
    input wire logic query_pending,
    input wire logic response_done,
    input wire logic dsr,
    output logic dtr
);
    typedef struct packed {
        rsdte_pkg::rsdte_cfg_t cfg;
        logic [15:0] div;
        logic tick;
        rsdte_pkg::rsdte_tstate_t tst;
        logic [3:0] ticks;
        logic [3:0] bits;
        logic [1:0] stops;
        logic [7:0] sh;
        logic par;
        logic tx_ready;
        logic txd;
        logic talk_hold;
        logic dtr;
        rsdte_pkg::rsdte_rx_t rx_out;
    } rsdte_top_t;

    rsdte_top_t s;
    rsdte_top_t next_s;
    rsdte_pkg::rsdte_rx_t rx_w;
    logic [15:0] div_end;
    logic [3:0] nbits;
    logic par_on;

    // dividers follow the clock rate, so a slower clock keeps the same baud set
    localparam logic [15:0] D300 = 16'(CLK_HZ / (rsdte_pkg::BAUD_300 * rsdte_pkg::OVERSAMPLE));
    localparam logic [15:0] D600 = 16'(CLK_HZ / (rsdte_pkg::BAUD_600 * rsdte_pkg::OVERSAMPLE));
    localparam logic [15:0] D1200 = 16'(CLK_HZ / (rsdte_pkg::BAUD_1200 * rsdte_pkg::OVERSAMPLE));
    localparam logic [15:0] D2400 = 16'(CLK_HZ / (rsdte_pkg::BAUD_2400 * rsdte_pkg::OVERSAMPLE));
    localparam logic [15:0] D4800 = 16'(CLK_HZ / (rsdte_pkg::BAUD_4800 * rsdte_pkg::OVERSAMPLE));
    localparam logic [15:0] D9600 = 16'(CLK_HZ / (rsdte_pkg::BAUD_9600 * rsdte_pkg::OVERSAMPLE));

    // divider reload per baud choice
    always_comb begin
        case (s.cfg.baud)
            rsdte_pkg::RSDTE_B300: div_end = D300;
            rsdte_pkg::RSDTE_B600: div_end = D600;
            rsdte_pkg::RSDTE_B1200: div_end = D1200;
            rsdte_pkg::RSDTE_B2400: div_end = D2400;
            rsdte_pkg::RSDTE_B4800: div_end = D4800;
            default: div_end = D9600;
        endcase
    end

    assign par_on = (s.cfg.parity != rsdte_pkg::RSDTE_PAR_NONE);
    assign nbits = par_on ? rsdte_pkg::BITS_W7 : rsdte_pkg::BITS_W8;

    always_comb begin
        next_s = s;
        next_s.rx_out = rx_w;
        // config only changes between transmit frames; a frame being received can still be torn
        if (cfg_load && s.tst == rsdte_pkg::RSDTE_T_IDLE && !tx_in.valid) begin
            next_s.cfg = cfg_in;
            if (cfg_in.parity != rsdte_pkg::RSDTE_PAR_NONE
                && cfg_in.parity != rsdte_pkg::RSDTE_PAR_EVEN
                && cfg_in.parity != rsdte_pkg::RSDTE_PAR_ODD) begin
                next_s.cfg.parity = rsdte_pkg::PARITY_RESET;
            end
            if (cfg_in.baud > rsdte_pkg::RSDTE_B9600) begin
                next_s.cfg.baud = rsdte_pkg::BAUD_RESET;
            end
        end
        // sixteen-times oversample tick
        next_s.tick = 1'b0;
        if (s.div >= div_end - rsdte_pkg::DIV_ONE) begin
            next_s.div = rsdte_pkg::DIV_ZERO;
            next_s.tick = 1'b1;
        end else begin
            next_s.div = s.div + rsdte_pkg::DIV_ONE;
        end
        // talk hold: set on query with newline, cleared when response out
        if (query_pending) begin
            next_s.talk_hold = 1'b1;
        end else if (response_done) begin
            next_s.talk_hold = 1'b0;
        end
        next_s.dtr = !(s.talk_hold || query_pending)
                     && (rx_level < rsdte_pkg::RX_FULL_LEVEL);
        next_s.tx_ready = 1'b0;
        if (s.tick) begin
            next_s.ticks = s.ticks + 4'h1;
        end
        // transmitter walk
        case (s.tst)
            rsdte_pkg::RSDTE_T_IDLE: begin
                next_s.txd = rsdte_pkg::MARK;
                if (tx_in.valid && dsr && !s.tx_ready) begin
                    next_s.tx_ready = 1'b1;
                    next_s.sh = tx_in.data;
                    next_s.par = (s.cfg.parity == rsdte_pkg::RSDTE_PAR_ODD);
                    next_s.tst = rsdte_pkg::RSDTE_T_START;
                    next_s.ticks = rsdte_pkg::BITS_ZERO;
                    next_s.txd = rsdte_pkg::SPACE;
                end
            end
            rsdte_pkg::RSDTE_T_START: begin
                if (s.tick && s.ticks == rsdte_pkg::TICK_LAST) begin
                    next_s.tst = rsdte_pkg::RSDTE_T_DATA;
                    next_s.bits = rsdte_pkg::BITS_ZERO;
                    next_s.txd = s.sh[0];
                end
            end
            rsdte_pkg::RSDTE_T_DATA: begin
                if (s.tick && s.ticks == rsdte_pkg::TICK_LAST) begin
                    next_s.par = s.par ^ s.sh[0];
                    next_s.sh = {1'b0, s.sh[7:1]};
                    next_s.bits = s.bits + 4'h1;
                    if (s.bits + 4'h1 == nbits) begin
                        if (par_on) begin
                            next_s.tst = rsdte_pkg::RSDTE_T_PAR;
                            next_s.txd = s.par ^ s.sh[0];
                        end else begin
                            next_s.tst = rsdte_pkg::RSDTE_T_STOP;
                            next_s.stops = 2'h0;
                            next_s.txd = rsdte_pkg::MARK;
                        end
                    end else begin
                        next_s.txd = s.sh[1];
                    end
                end
            end
            rsdte_pkg::RSDTE_T_PAR: begin
                if (s.tick && s.ticks == rsdte_pkg::TICK_LAST) begin
                    next_s.tst = rsdte_pkg::RSDTE_T_STOP;
                    next_s.stops = 2'h0;
                    next_s.txd = rsdte_pkg::MARK;
                end
            end
            rsdte_pkg::RSDTE_T_STOP: begin
                if (s.tick && s.ticks == rsdte_pkg::TICK_LAST) begin
                    next_s.stops = s.stops + 2'h1;
                    if (s.stops == rsdte_pkg::STOPS_LAST) begin
                        next_s.tst = rsdte_pkg::RSDTE_T_IDLE;
                    end
                end
            end
            default: begin
                next_s.tst = rsdte_pkg::RSDTE_T_IDLE;
            end
        endcase
        // received chars are dropped while hold-off is raised
        next_s.rx_out.valid = rx_w.valid && s.dtr;
    end

    // reset gives the factory setting
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s <= '0;
            s.cfg.baud <= rsdte_pkg::BAUD_RESET;
            s.cfg.parity <= rsdte_pkg::PARITY_RESET;
            s.txd <= rsdte_pkg::MARK;
            s.dtr <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    rsdte_rx u_rx (
        .clk(clk),
        .reset(reset),
        .tick(s.tick),
        .cfg(s.cfg),
        .rxd(rxd),
        .rx(rx_w)
    );

    assign tx_ready = s.tx_ready;
    assign txd = s.txd;
    assign dtr = s.dtr;
    assign rx_out = s.rx_out;
endmodule

// file: verilog/rsdte_pkg.sv
// package: constants and carrier types for the terminal-side serial port
package rsdte_pkg;
    localparam int unsigned CLK_HZ = 250_000_000;
    // baud settings, index 0..5 = 300,600,1200,2400,4800,9600
    localparam int unsigned BAUD_300 = 300;
    localparam int unsigned BAUD_600 = 600;
    localparam int unsigned BAUD_1200 = 1200;
    localparam int unsigned BAUD_2400 = 2400;
    localparam int unsigned BAUD_4800 = 4800;
    localparam int unsigned BAUD_9600 = 9600;
    localparam int unsigned OVERSAMPLE = 16;
    localparam int DIV_W = 16;
    // cycles per sixteenth of a bit, rounded down
    localparam logic [DIV_W-1:0] DIV_300 = DIV_W'(CLK_HZ / (BAUD_300 * OVERSAMPLE));
    localparam logic [DIV_W-1:0] DIV_600 = DIV_W'(CLK_HZ / (BAUD_600 * OVERSAMPLE));
    localparam logic [DIV_W-1:0] DIV_1200 = DIV_W'(CLK_HZ / (BAUD_1200 * OVERSAMPLE));
    localparam logic [DIV_W-1:0] DIV_2400 = DIV_W'(CLK_HZ / (BAUD_2400 * OVERSAMPLE));
    localparam logic [DIV_W-1:0] DIV_4800 = DIV_W'(CLK_HZ / (BAUD_4800 * OVERSAMPLE));
    localparam logic [DIV_W-1:0] DIV_9600 = DIV_W'(CLK_HZ / (BAUD_9600 * OVERSAMPLE));

    typedef enum logic [2:0] {
        RSDTE_B300 = 3'h0,
        RSDTE_B600 = 3'h1,
        RSDTE_B1200 = 3'h2,
        RSDTE_B2400 = 3'h3,
        RSDTE_B4800 = 3'h4,
        RSDTE_B9600 = 3'h5
    } rsdte_baud_t;

    typedef enum logic [1:0] {
        RSDTE_PAR_NONE = 2'h0,
        RSDTE_PAR_EVEN = 2'h1,
        RSDTE_PAR_ODD = 2'h2
    } rsdte_parity_t;

    localparam rsdte_baud_t BAUD_RESET = RSDTE_B9600;
    localparam rsdte_parity_t PARITY_RESET = RSDTE_PAR_EVEN;

    localparam int unsigned DATA_BITS_PAR = 7;
    localparam int unsigned DATA_BITS_NOPAR = 8;
    localparam int unsigned STOP_BITS = 2;
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] BITS_W7 = 4'h7;
    localparam logic [3:0] BITS_W8 = 4'h8;
    localparam logic [3:0] BITS_ZERO = 4'h0;
    localparam logic [1:0] STOPS_LAST = 2'h1;
    localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;
    localparam logic [DIV_W-1:0] DIV_ZERO = 16'h0000;

    // receive buffer fill level at which hold-off is raised
    localparam int LVL_W = 8;
    localparam logic [LVL_W-1:0] RX_FULL_LEVEL = 8'h64;

    localparam logic MARK = 1'b1;
    localparam logic SPACE = 1'b0;

    typedef struct packed {
        rsdte_baud_t baud;
        rsdte_parity_t parity;
    } rsdte_cfg_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } rsdte_char_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic parity_err;
        logic frame_err;
    } rsdte_rx_t;

    typedef enum logic [1:0] {
        RSDTE_IDLE = 2'h0,
        RSDTE_START = 2'h1,
        RSDTE_DATA = 2'h2,
        RSDTE_STOP = 2'h3
    } rsdte_state_t;

    typedef enum logic [2:0] {
        RSDTE_T_IDLE = 3'h0,
        RSDTE_T_START = 3'h1,
        RSDTE_T_DATA = 3'h2,
        RSDTE_T_PAR = 3'h3,
        RSDTE_T_STOP = 3'h4
    } rsdte_tstate_t;
endpackage

// file: verilog/rsdte_rx.sv
// receiver: samples the line at sixteen ticks per bit and rebuilds characters
`timescale 1ns/1ps
module rsdte_rx (
    input wire logic clk,
    input wire logic reset,
    input wire logic tick,
    input wire rsdte_pkg::rsdte_cfg_t cfg,
    input wire logic rxd,
    output rsdte_pkg::rsdte_rx_t rx
);
    typedef struct packed {
        rsdte_pkg::rsdte_state_t st;
        logic [3:0] ticks;
        logic [3:0] bits;
        logic [1:0] stops;
        logic [7:0] shreg;
        logic par_acc;
        logic par_bit;
        logic ferr;
        rsdte_pkg::rsdte_rx_t out;
    } rsdte_rxs_t;

    rsdte_rxs_t s;
    rsdte_rxs_t next_s;
    logic [3:0] nbits;

    // data width follows parity choice
    assign nbits = (cfg.parity == rsdte_pkg::RSDTE_PAR_NONE) ? rsdte_pkg::BITS_W8
                                                              : rsdte_pkg::BITS_W7;

    // frame walk: start, data lsb first, optional parity, two stops
    always_comb begin
        next_s = s;
        next_s.out.valid = 1'b0;
        if (tick) begin
            next_s.ticks = s.ticks + 4'h1;
            case (s.st)
                rsdte_pkg::RSDTE_IDLE: begin
                    next_s.ticks = rsdte_pkg::BITS_ZERO;
                    if (rxd == rsdte_pkg::SPACE) begin
                        next_s.st = rsdte_pkg::RSDTE_START;
                    end
                end
                rsdte_pkg::RSDTE_START: begin
                    // a glitch shorter than half a bit is dropped
                    if (s.ticks == rsdte_pkg::TICK_MID) begin
                        next_s.ticks = rsdte_pkg::BITS_ZERO;
                        next_s.bits = rsdte_pkg::BITS_ZERO;
                        next_s.shreg = 8'h00;
                        next_s.par_acc = 1'b0;
                        next_s.ferr = 1'b0;
                        next_s.st = (rxd == rsdte_pkg::SPACE) ? rsdte_pkg::RSDTE_DATA
                                                              : rsdte_pkg::RSDTE_IDLE;
                    end
                end
                rsdte_pkg::RSDTE_DATA: begin
                    if (s.ticks == rsdte_pkg::TICK_LAST) begin
                        // mid-bit sample, parity taken as extra bit after data
                        if (s.bits == nbits) begin
                            next_s.par_bit = rxd;
                            next_s.st = rsdte_pkg::RSDTE_STOP;
                            next_s.stops = 2'h0;
                        end else begin
                            next_s.shreg = {rxd, s.shreg[7:1]};
                            next_s.par_acc = s.par_acc ^ rxd;
                            next_s.bits = s.bits + 4'h1;
                            if (s.bits + 4'h1 == nbits
                                && cfg.parity == rsdte_pkg::RSDTE_PAR_NONE) begin
                                next_s.st = rsdte_pkg::RSDTE_STOP;
                                next_s.stops = 2'h0;
                            end
                        end
                    end
                end
                rsdte_pkg::RSDTE_STOP: begin
                    if (s.ticks == rsdte_pkg::TICK_LAST) begin
                        next_s.stops = s.stops + 2'h1;
                        if (rxd == rsdte_pkg::SPACE) begin
                            next_s.ferr = 1'b1;
                        end
                        if (s.stops == rsdte_pkg::STOPS_LAST) begin
                            next_s.st = rsdte_pkg::RSDTE_IDLE;
                            next_s.out.valid = 1'b1;
                            next_s.out.data = (nbits == rsdte_pkg::BITS_W7)
                                ? {1'b0, s.shreg[7:1]} : s.shreg;
                            next_s.out.frame_err = s.ferr | (rxd == rsdte_pkg::SPACE);
                            next_s.out.parity_err =
                                (cfg.parity == rsdte_pkg::RSDTE_PAR_EVEN
                                 && (s.par_acc ^ s.par_bit))
                                || (cfg.parity == rsdte_pkg::RSDTE_PAR_ODD
                                 && !(s.par_acc ^ s.par_bit));
                        end
                    end
                end
                default: begin
                    next_s.st = rsdte_pkg::RSDTE_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rx = s.out;
endmodule

// file: test/rsdte_port_props.sv
// checker: port-level assertions for the terminal-side serial port
`timescale 1ns/1ps
module rsdte_port_props #(
    parameter int unsigned CLK_HZ = rsdte_pkg::CLK_HZ
) (
    input wire logic clk,
    input wire logic reset,
    input wire rsdte_pkg::rsdte_char_t tx_in,
    input wire logic tx_ready,
    input wire logic txd,
    input wire rsdte_pkg::rsdte_rx_t rx_out,
    input wire logic [7:0] rx_level,
    input wire logic query_pending,
    input wire logic dsr,
    input wire logic dtr
);
    // bit time at 9600 baud; the timing checks assume that rate, which the bench leaves only for one frame at 4800
    localparam int TICK = int'(CLK_HZ / (rsdte_pkg::BAUD_9600 * rsdte_pkg::OVERSAMPLE));
    localparam int BIT = 16 * TICK;
    logic [19:0] age;

    // cycles since the last accepted character, saturating so idle gaps never wrap
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            age <= 20'hfffff;
        end else if (tx_ready) begin
            age <= 20'h00001;
        end else if (age != 20'hfffff) begin
            age <= age + 20'h00001;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    a_reset_idle: assert property ($fell(reset) |-> txd && !tx_ready)
        else $error("line not idle after reset");
    a_start_low: assert property (age == BIT / 2 |-> !txd)
        else $error("start bit not at space mid-bit");
    a_two_stops: assert property (age == 9 * BIT + BIT / 2 || age == 10 * BIT + BIT / 2 |-> txd)
        else $error("stop bit not at mark");
    // start bit may lose up to one tick, since the divider runs free of the frame
    a_frame_span: assert property (tx_ready && age != 20'hfffff |-> age >= 10 * BIT + 15 * TICK)
        else $error("next frame started before both stops ended");
    a_dsr_gate: assert property ($rose(tx_ready) |-> $past(dsr) && $past(tx_in.valid))
        else $error("character taken without partner ready");
    a_dtr_full: assert property (rx_level >= 8'h64 |=> !dtr)
        else $error("hold-off missing with full buffer");
    a_dtr_query: assert property (query_pending |=> !dtr)
        else $error("hold-off missing while query pending");
    a_dtr_rise: assert property ($rose(dtr) |-> $past(rx_level) < 8'h64 && !$past(query_pending))
        else $error("ready raised while a hold-off cause stood");
    a_rx_gated: assert property (rx_out.valid |-> $past(dtr))
        else $error("character flagged during hold-off");
    a_rx_pulse: assert property (rx_out.valid |=> !rx_out.valid)
        else $error("receive valid longer than one cycle");
endmodule

bind rsdte_port rsdte_port_props #(.CLK_HZ(CLK_HZ)) u_props (.clk(clk), .reset(reset), .tx_in(tx_in),
    .tx_ready(tx_ready), .txd(txd), .rx_out(rx_out), .rx_level(rx_level),
    .query_pending(query_pending), .dsr(dsr), .dtr(dtr));

// file: test/rsdte_host.sv
// host model: far-side serial port that sends and captures frames
`timescale 1ns/1ps
module rsdte_host #(
    parameter int BIT = 26032 // same rate as the device
) (
    input wire logic clk,
    input wire logic txd,
    output logic rxd,
    output logic dsr
);
    // line idles at mark, host ready to receive
    initial begin
        rxd = 1'b1;
        dsr = 1'b1;
    end

    // one frame lsb first; sent even under hold-off, since ten more characters may follow
    task automatic send(input logic [10:0] f);
        for (int i = 0; i < 11; i++) begin
            @(negedge clk);
            rxd = f[i];
            repeat (BIT - 1) @(negedge clk);
        end
        @(negedge clk);
        rxd = 1'b1;
    endtask

    // capture at mid-bit; sampled on the falling edge to stay clear of launch edges
    task automatic recv(output logic [10:0] f);
        int n;
        n = 0;
        f = 11'h7ff;
        while (txd === 1'b1 && n < 4 * BIT) begin
            @(negedge clk);
            n++;
        end
        repeat (BIT / 2) @(negedge clk);
        for (int i = 0; i < 11; i++) begin
            f[i] = txd;
            repeat (BIT) @(negedge clk);
        end
    endtask
endmodule

// file: test/rsdte_port_tb_top.sv
// testbench: frame, hold-off and receive scenarios for the serial port
`timescale 1ns/1ps
module rsdte_port_tb_top;
    // port run as if clocked slowly, so one frame is about seven hundred cycles
    localparam int unsigned CLK_SIM = 614_400;
    localparam int D4800 = int'(CLK_SIM / (rsdte_pkg::BAUD_4800 * rsdte_pkg::OVERSAMPLE));
    localparam int BIT = 16 * int'(CLK_SIM / (rsdte_pkg::BAUD_9600 * rsdte_pkg::OVERSAMPLE));
    logic clk, reset, cfg_load, tx_ready, txd, rxd, query_pending, response_done, dsr, dtr;
    logic [7:0] rx_level;
    rsdte_pkg::rsdte_cfg_t cfg_in;
    rsdte_pkg::rsdte_char_t tx_in;
    rsdte_pkg::rsdte_rx_t rx_out;
    int mismatches, tests_run;
    int cycles = 0;

    rsdte_port #(.CLK_HZ(CLK_SIM)) dut (.clk(clk), .reset(reset), .cfg_in(cfg_in), .cfg_load(cfg_load),
        .tx_in(tx_in), .tx_ready(tx_ready), .txd(txd), .rxd(rxd), .rx_out(rx_out),
        .rx_level(rx_level), .query_pending(query_pending), .response_done(response_done),
        .dsr(dsr), .dtr(dtr));
    rsdte_host #(.BIT(BIT)) host (.clk(clk), .txd(txd), .rxd(rxd), .dsr(dsr));

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // expected wire frame, bit 0 = start
    function automatic logic [10:0] frame(input logic [7:0] d, input rsdte_pkg::rsdte_parity_t p);
        if (p == rsdte_pkg::RSDTE_PAR_NONE) return {2'h3, d, 1'h0};
        return {2'h3, (p == rsdte_pkg::RSDTE_PAR_ODD) ^ (^d[6:0]), d[6:0], 1'h0};
    endfunction

    task automatic set_cfg(input rsdte_pkg::rsdte_baud_t b, input rsdte_pkg::rsdte_parity_t p);
        @(negedge clk);
        cfg_in = '{baud: b, parity: p};
        cfg_load = 1'b1;
        @(negedge clk);
        cfg_load = 1'b0;
    endtask

    // send one character, optionally with the host stalling first
    task automatic t_tx(input logic [7:0] d, input rsdte_pkg::rsdte_parity_t p, input bit stall);
        logic [10:0] f;
        int n;
        n = 0;
        @(negedge clk);
        host.dsr = !stall;
        tx_in = '{valid: 1'b1, data: d};
        if (stall) begin
            repeat (200) @(negedge clk);
            check("tx_ready under stall", {10'h000, tx_ready}, 11'h000);
            check("line under stall", {10'h000, txd}, 11'h001);
            host.dsr = 1'b1;
        end
        while (tx_ready !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        tx_in.valid = 1'b0;
        check("tx accept", {10'h000, tx_ready}, 11'h001);
        host.recv(f);
        check("tx frame", f, frame(d, p));
        $display("test tx done");
    endtask

    // host sends one frame; receive output judged against exp
    task automatic t_rx(input logic [10:0] f, input rsdte_pkg::rsdte_rx_t exp);
        rsdte_pkg::rsdte_rx_t seen;
        seen = 11'h000;
        fork
            host.send(f);
            for (int n = 0; n < 12 * BIT && seen.valid !== 1'b1; n++) begin
                @(negedge clk);
                if (rx_out.valid === 1'b1) seen = rx_out;
            end
        join
        check("rx char", seen, exp);
        $display("test rx done");
    endtask

    // buffer-full and query hold-off, with a character arriving during hold-off
    task automatic t_holdoff();
        @(negedge clk);
        rx_level = 8'h64;
        repeat (2) @(negedge clk);
        check("dtr buffer full", {10'h000, dtr}, 11'h000);
        t_rx(frame(8'h5a, rsdte_pkg::RSDTE_PAR_NONE), 11'h000);
        rx_level = 8'h63;
        repeat (2) @(negedge clk);
        check("dtr space freed", {10'h000, dtr}, 11'h001);
        query_pending = 1'b1;
        repeat (2) @(negedge clk);
        check("dtr query hold", {10'h000, dtr}, 11'h000);
        query_pending = 1'b0;
        response_done = 1'b1;
        @(negedge clk);
        response_done = 1'b0;
        repeat (2) @(negedge clk);
        check("dtr after response", {10'h000, dtr}, 11'h001);
        $display("test holdoff done");
    endtask

    // slower setting: the start bit must span fifteen to sixteen ticks of the 4800 divider
    task automatic t_baud();
        int n;
        n = 0;
        set_cfg(rsdte_pkg::RSDTE_B4800, rsdte_pkg::RSDTE_PAR_NONE);
        @(negedge clk);
        tx_in = '{valid: 1'b1, data: 8'hff};
        while (tx_ready !== 1'b1) @(negedge clk);
        tx_in.valid = 1'b0;
        while (txd === 1'b0) begin
            @(negedge clk);
            n++;
        end
        check("start span 4800", {10'h000, n >= 15 * D4800 && n <= 16 * D4800}, 11'h001);
        repeat (24 * BIT) @(negedge clk);
        set_cfg(rsdte_pkg::RSDTE_B9600, rsdte_pkg::RSDTE_PAR_NONE);
        $display("test baud done");
    endtask

    task automatic give_verdict();
        $display("checks run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ceiling of fourteen frame times; the run needs about ten
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 14 * 11 * BIT) begin
            mismatches++;
            give_verdict();
        end
    end

    // cfg_in holds a non-default value that is never loaded, so the first frame shows the default
    initial begin
        reset = 1'b1;
        cfg_load = 1'b0;
        cfg_in = '{baud: rsdte_pkg::RSDTE_B300, parity: rsdte_pkg::RSDTE_PAR_ODD};
        tx_in = 9'h000;
        rx_level = 8'h00;
        query_pending = 1'b0;
        response_done = 1'b0;
        mismatches = 0;
        tests_run = 0;
        repeat (8) @(negedge clk);
        reset = 1'b0;
        repeat (2) @(negedge clk);
        check("idle after reset", {9'h000, txd, dtr}, 11'h003);
        t_tx(8'hd3, rsdte_pkg::RSDTE_PAR_EVEN, 1'b0);
        set_cfg(rsdte_pkg::RSDTE_B9600, rsdte_pkg::RSDTE_PAR_ODD);
        t_tx(8'h2c, rsdte_pkg::RSDTE_PAR_ODD, 1'b0);
        set_cfg(rsdte_pkg::RSDTE_B9600, rsdte_pkg::RSDTE_PAR_NONE);
        t_tx(8'hb7, rsdte_pkg::RSDTE_PAR_NONE, 1'b1);
        t_baud();
        t_rx(frame(8'ha5, rsdte_pkg::RSDTE_PAR_NONE), '{1'b1, 8'ha5, 1'b0, 1'b0});
        t_rx(frame(8'h3c, rsdte_pkg::RSDTE_PAR_NONE) & 11'h1ff, '{1'b1, 8'h3c, 1'b0, 1'b1});
        t_holdoff();
        set_cfg(rsdte_pkg::RSDTE_B9600, rsdte_pkg::RSDTE_PAR_EVEN);
        t_rx(frame(8'h41, rsdte_pkg::RSDTE_PAR_EVEN) ^ 11'h100, '{1'b1, 8'h41, 1'b1, 1'b0});
        give_verdict();
    end
endmodule
